// ===== logic/aao_alu.sv
// The implementer's own choices: the strobed register port and the address map.
`include "aao_alu_cfg.svh"
`default_nettype none

// Contract
// - Add-with-carry to file sums accumulator, carry and file byte into the destination.
// - Add-with-carry to file decodes from upper six bits 001000.
// - Every add updates negative, overflow, carry, half carry and zero from its sum.
// - Destination bit clear: result goes to accumulator, file register untouched.
// - Destination bit set: result goes back to the file register instead.
// - Bank bit clear: the file address resolves inside the access bank.
// - Bank bit set: bank select register supplies the bank beside the file address.
// - Extended set with bank bit clear and address up to 95 uses indexed offset.
// - AND literal puts accumulator AND immediate byte into the accumulator.
// - AND literal decodes from upper byte 0000 1011, immediate in lower byte.
// - AND literal changes only negative and zero, other flags keep their value.
module aao_alu (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_register,
  output logic [11:0]      file_addr,
  output logic             file_indexed,
  output logic             file_rd_en,
  input  wire logic [7:0]  file_rd_data,
  output logic             file_wr_en,
  output logic [7:0]       file_wr_data,
  output logic [7:0]       accumulator,
  output logic             negative_flag,
  output logic             signed_wrap_flag,
  output logic             zero_flag,
  output logic             half_carry_flag,
  output logic             carry_flag,
  output logic             instr_done,
  output logic             instr_unsupported
);
  import aao_alu_pkg::*;

  aao_state_type st_q;
  aao_state_type st_d;

  logic [7:0] opa;
  logic [7:0] opb;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] fld;
  logic       is_file;
  logic       is_add;

  always_comb begin
    opa     = st_q.acc;
    opb     = 8'h00;
    cin     = 1'b0;
    sum9    = 9'h000;
    lo5     = 5'h00;
    fld     = st_q.instr[`AAO_FIELD_HI:`AAO_FIELD_LO];
    is_file = (st_q.op == AAO_OP_ADDFILE) || (st_q.op == AAO_OP_ADCFILE);
    is_add  = is_file || (st_q.op == AAO_OP_ADDLIT);
    st_d        = st_q;
    st_d.rd_en  = 1'b0;
    st_d.wr_en  = 1'b0;
    st_d.done   = 1'b0;
    unique case (st_q.phase)
      AAO_IDLE: begin
        if (instr_valid) begin
          st_d.instr = instr_word;
          st_d.phase = AAO_DEC;
        end
      end
      AAO_DEC: begin
        if (st_q.instr[`AAO_BYTE_OP_HI:`AAO_BYTE_OP_LO] == `AAO_OP_ADD_LIT) begin
          st_d.op = AAO_OP_ADDLIT;
        end else if (st_q.instr[`AAO_BYTE_OP_HI:`AAO_BYTE_OP_LO] == `AAO_OP_AND_LIT) begin
          st_d.op = AAO_OP_ANDLIT;
        end else if (st_q.instr[`AAO_FILE_OP_HI:`AAO_FILE_OP_LO] == `AAO_OP_ADD_FILE) begin
          st_d.op = AAO_OP_ADDFILE;
        end else if (st_q.instr[`AAO_FILE_OP_HI:`AAO_FILE_OP_LO] == `AAO_OP_ADC_FILE) begin
          st_d.op = AAO_OP_ADCFILE;
        end else begin
          st_d.op = AAO_OP_NONE;
        end
        st_d.indexed = 1'b0;
        if (st_q.instr[`AAO_BANK_BIT]) begin
          st_d.addr = {bank_select_register, fld};
        end else if (ext_set_en && (fld <= `AAO_ACCESS_LIMIT)) begin
          st_d.indexed = 1'b1;
          st_d.addr    = {`AAO_ACCESS_LOW_BANK, fld};
        end else if (fld <= `AAO_ACCESS_LIMIT) begin
          st_d.addr = {`AAO_ACCESS_LOW_BANK, fld};
        end else begin
          st_d.addr = {`AAO_ACCESS_HIGH_BANK, fld};
        end
        st_d.rd_en = (st_d.op == AAO_OP_ADDFILE) || (st_d.op == AAO_OP_ADCFILE);
        st_d.phase = AAO_RD;
      end
      AAO_RD: begin
        st_d.phase = AAO_PROC;
      end
      AAO_PROC: begin
        // File data answers one cycle after the read strobe, so it is valid here.
        opb  = is_file ? file_rd_data : fld;
        cin  = (st_q.op == AAO_OP_ADCFILE) ? st_q.c : 1'b0;
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
        lo5  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        st_d.n_new  = st_q.n;
        st_d.ov_new = st_q.ov;
        st_d.z_new  = st_q.z;
        st_d.dc_new = st_q.dc;
        st_d.c_new  = st_q.c;
        st_d.result = st_q.acc;
        if (is_add) begin
          st_d.result = sum9[7:0];
          st_d.c_new  = sum9[8];
          st_d.dc_new = lo5[4];
          st_d.ov_new = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
          st_d.n_new  = sum9[7];
          st_d.z_new  = (sum9[7:0] == 8'h00);
        end else if (st_q.op == AAO_OP_ANDLIT) begin
          st_d.result = opa & opb;
          st_d.n_new  = st_d.result[7];
          st_d.z_new  = (st_d.result == 8'h00);
        end
        st_d.wr_en = is_file && st_q.instr[`AAO_DEST_BIT];
        st_d.phase = AAO_WR;
      end
      AAO_WR: begin
        if (st_q.op != AAO_OP_NONE) begin
          st_d.n  = st_q.n_new;
          st_d.ov = st_q.ov_new;
          st_d.z  = st_q.z_new;
          st_d.dc = st_q.dc_new;
          st_d.c  = st_q.c_new;
        end
        if (!st_q.wr_en && (st_q.op != AAO_OP_NONE)) begin
          st_d.acc = st_q.result;
        end
        st_d.unsupported = (st_q.op == AAO_OP_NONE);
        st_d.done        = 1'b1;
        st_d.phase       = AAO_IDLE;
      end
      default: begin
        st_d.phase = AAO_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q.phase       <= AAO_IDLE;
      st_q.op          <= AAO_OP_NONE;
      st_q.instr       <= `AAO_INSTR_RST;
      st_q.acc         <= `AAO_ACC_RST;
      st_q.n           <= `AAO_FLAG_RST;
      st_q.ov          <= `AAO_FLAG_RST;
      st_q.z           <= `AAO_FLAG_RST;
      st_q.dc          <= `AAO_FLAG_RST;
      st_q.c           <= `AAO_FLAG_RST;
      st_q.n_new       <= `AAO_FLAG_RST;
      st_q.ov_new      <= `AAO_FLAG_RST;
      st_q.z_new       <= `AAO_FLAG_RST;
      st_q.dc_new      <= `AAO_FLAG_RST;
      st_q.c_new       <= `AAO_FLAG_RST;
      st_q.result      <= `AAO_ACC_RST;
      st_q.addr        <= `AAO_ADDR_RST;
      st_q.indexed     <= 1'b0;
      st_q.rd_en       <= 1'b0;
      st_q.wr_en       <= 1'b0;
      st_q.done        <= 1'b0;
      st_q.unsupported <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign instr_ready       = (st_q.phase == AAO_IDLE);
  assign file_addr         = st_q.addr;
  assign file_indexed      = st_q.indexed;
  assign file_rd_en        = st_q.rd_en;
  assign file_wr_en        = st_q.wr_en;
  assign file_wr_data      = st_q.result;
  assign accumulator       = st_q.acc;
  assign negative_flag     = st_q.n;
  assign signed_wrap_flag  = st_q.ov;
  assign zero_flag         = st_q.z;
  assign half_carry_flag   = st_q.dc;
  assign carry_flag        = st_q.c;
  assign instr_done        = st_q.done;
  assign instr_unsupported = st_q.unsupported;

  adc_sum_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADCFILE)
    |=> st_q.result == 8'($past(file_rd_data) + $past(st_q.acc) + {7'h00, $past(st_q.c)}))
    else $error("add with carry result wrong");

  adc_decode_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_DEC) && (st_q.instr[15:10] == 6'h08)
    |=> (st_q.op == AAO_OP_ADCFILE) && file_rd_en)
    else $error("add with carry not decoded");

  add_flags_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op != AAO_OP_NONE) && (st_q.op != AAO_OP_ANDLIT)
    |=> (zero_flag == ($past(st_q.result) == 8'h00))
        && (negative_flag == $past(st_q.result[7])))
    else $error("add flags not taken from the sum");

  dest_acc_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_ADDFILE) && !st_q.instr[9]
    |-> !file_wr_en ##1 (accumulator == $past(st_q.result)))
    else $error("accumulator destination not honoured");

  dest_file_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_ADCFILE) && st_q.instr[9]
    |-> (file_wr_en && (file_wr_data == st_q.result)) ##1 $stable(accumulator))
    else $error("file destination not honoured");

  access_bank_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_RD) && file_rd_en && !st_q.instr[8] && !$past(ext_set_en)
    |-> !file_indexed && (file_addr[7:0] == st_q.instr[7:0])
        && (file_addr[11:8] == ((st_q.instr[7:0] <= 8'h5f) ? 4'h0 : 4'hf)))
    else $error("access bank address wrong");

  bank_reg_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_RD) && file_rd_en && st_q.instr[8]
    |-> !file_indexed && (file_addr == {$past(bank_select_register), st_q.instr[7:0]}))
    else $error("bank select address wrong");

  indexed_mode_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_RD) && file_rd_en
    |-> file_indexed == (!st_q.instr[8] && $past(ext_set_en) && (st_q.instr[7:0] <= 8'h5f)))
    else $error("indexed offset mode wrong");

  and_result_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ANDLIT)
    |=> ##1 (accumulator == ($past(st_q.acc, 2) & $past(st_q.instr[7:0], 2))))
    else $error("and literal result wrong");

  and_decode_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_DEC) && (st_q.instr[15:8] == 8'h0b)
    |=> (st_q.op == AAO_OP_ANDLIT) && !file_rd_en)
    else $error("and literal not decoded");

  and_flags_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_ANDLIT)
    |=> $stable(carry_flag) && $stable(half_carry_flag) && $stable(signed_wrap_flag)
        && (zero_flag == (accumulator == 8'h00)) && (negative_flag == accumulator[7]))
    else $error("and literal touched arithmetic flags");

  add_lit_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADDLIT)
    |=> ##1 (accumulator == 8'($past(st_q.acc, 2) + $past(st_q.instr[7:0], 2)))
        && (carry_flag == ((9'($past(st_q.acc, 2)) + 9'($past(st_q.instr[7:0], 2))) > 9'h0ff)))
    else $error("add literal wrong");

  one_cycle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    instr_valid && instr_ready
    |=> (st_q.phase == AAO_DEC) ##1 (st_q.phase == AAO_RD) ##1 (st_q.phase == AAO_PROC)
        ##1 (st_q.phase == AAO_WR) ##1 (instr_done && instr_ready))
    else $error("instruction phases out of order");

  read_pulse_a: assert property (
    @(posedge core_clk) disable iff (rst)
    file_rd_en |=> !file_rd_en ##1 !file_rd_en)
    else $error("file read strobe longer than one cycle");

  write_slot_a: assert property (
    @(posedge core_clk) disable iff (rst)
    file_rd_en |-> ##2 (file_wr_en == st_q.instr[`AAO_DEST_BIT]))
    else $error("file write not two cycles after the read");

  literal_no_file_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_RD) && ((st_q.op == AAO_OP_ADDLIT) || (st_q.op == AAO_OP_ANDLIT))
    |-> !file_rd_en ##2 !file_wr_en)
    else $error("literal instruction touched the file");

  done_pulse_a: assert property (
    @(posedge core_clk) disable iff (rst)
    instr_done |-> instr_ready ##1 !instr_done)
    else $error("done pulse malformed");

  add_file_sum_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADDFILE)
    |=> st_q.result == 8'($past(file_rd_data) + $past(st_q.acc)))
    else $error("add to file result wrong");

  adc_carry_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADCFILE)
    |=> st_q.c_new == ((9'($past(file_rd_data)) + 9'($past(st_q.acc))
                        + 9'($past(st_q.c))) > 9'h0ff))
    else $error("add with carry carry out wrong");

  half_carry_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADDLIT)
    |=> st_q.dc_new == ((5'($past(st_q.acc[3:0])) + 5'($past(st_q.instr[3:0]))) > 5'h0f))
    else $error("half carry wrong");

  signed_wrap_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) && (st_q.op == AAO_OP_ADDLIT)
    |=> st_q.ov_new == (($past(st_q.acc[7]) == $past(st_q.instr[7]))
                        && (st_q.result[7] != $past(st_q.acc[7]))))
    else $error("signed wrap flag wrong");

  adc_to_acc_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_ADCFILE) && !st_q.instr[9]
    |-> !file_wr_en ##1 (accumulator == $past(st_q.result)))
    else $error("add with carry accumulator destination wrong");

  add_to_file_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_ADDFILE) && st_q.instr[9]
    |-> (file_wr_en && (file_wr_data == st_q.result)) ##1 $stable(accumulator))
    else $error("add to file destination wrong");

  unknown_op_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_WR) && (st_q.op == AAO_OP_NONE)
    |=> instr_unsupported && $stable(accumulator) && $stable(carry_flag)
        && $stable(zero_flag) && $stable(negative_flag))
    else $error("unsupported word changed state");

  bank_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_q.phase == AAO_PROC) || (st_q.phase == AAO_WR)
    |-> $stable(file_addr) && $stable(file_indexed))
    else $error("file address moved during the access");

endmodule : aao_alu

`default_nettype wire

// ===== logic/aao_alu_cfg.svh
`ifndef AAO_ALU_CFG_SVH
`define AAO_ALU_CFG_SVH

// Opcode patterns.
`define AAO_OP_ADD_LIT        8'h0f
`define AAO_OP_AND_LIT        8'h0b
`define AAO_OP_ADD_FILE       6'h09
`define AAO_OP_ADC_FILE       6'h08

// Field positions inside the instruction word.
`define AAO_BYTE_OP_HI        15
`define AAO_BYTE_OP_LO        8
`define AAO_FILE_OP_HI        15
`define AAO_FILE_OP_LO        10
`define AAO_DEST_BIT          9
`define AAO_BANK_BIT          8
`define AAO_FIELD_HI          7
`define AAO_FIELD_LO          0

// Addressing constants.
`define AAO_ACCESS_LIMIT      8'h5f
`define AAO_ACCESS_LOW_BANK   4'h0
`define AAO_ACCESS_HIGH_BANK  4'hf

// Reset values.
`define AAO_ACC_RST           8'h00
`define AAO_FLAG_RST          1'b0
`define AAO_INSTR_RST         16'h0000
`define AAO_ADDR_RST          12'h000

// Core clock cycles from the decode phase to the done pulse.
`define AAO_CYCLES_TO_DONE    4

`endif

// ===== logic/aao_alu_pkg.sv
`default_nettype none

package aao_alu_pkg;

  typedef enum logic [4:0] {
    AAO_IDLE = 5'h01,
    AAO_DEC  = 5'h02,
    AAO_RD   = 5'h04,
    AAO_PROC = 5'h08,
    AAO_WR   = 5'h10
  } aao_phase_type;

  typedef enum logic [4:0] {
    AAO_OP_NONE    = 5'h01,
    AAO_OP_ADDLIT  = 5'h02,
    AAO_OP_ANDLIT  = 5'h04,
    AAO_OP_ADDFILE = 5'h08,
    AAO_OP_ADCFILE = 5'h10
  } aao_op_type;

  typedef struct packed {
    aao_phase_type phase;
    aao_op_type    op;
    logic [15:0]   instr;
    logic [7:0]    acc;
    logic          n;
    logic          ov;
    logic          z;
    logic          dc;
    logic          c;
    logic          n_new;
    logic          ov_new;
    logic          z_new;
    logic          dc_new;
    logic          c_new;
    logic [7:0]    result;
    logic [11:0]   addr;
    logic          indexed;
    logic          rd_en;
    logic          wr_en;
    logic          done;
    logic          unsupported;
  } aao_state_type;

endpackage : aao_alu_pkg

`default_nettype wire

// ===== sim/aao_file_model.sv
`default_nettype none

module aao_file_model #(
  parameter logic [11:0] IDX_BASE = 12'h100
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_indexed,
  input  wire logic        file_rd_en,
  output var  logic [7:0]  file_rd_data,
  input  wire logic        file_wr_en,
  input  wire logic [7:0]  file_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  mem [0:4095];
  logic [11:0] eff;

  // Indexed accesses are an offset from a pointer that this side owns.
  assign eff = file_indexed ? IDX_BASE + {4'h0, file_addr[7:0]} : file_addr;

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'ha5;
    end
  end

  // Read data stand only in the cycle after the strobe; otherwise the bus toggles.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      file_rd_data <= 8'h00;
    end else if (file_rd_en) begin
      file_rd_data <= mem[eff];
    end else begin
      file_rd_data <= ~file_rd_data;
    end
  end

  always @(posedge core_clk) begin
    if (!rst && file_wr_en) begin
      mem[eff] <= file_wr_data;
    end
  end
endmodule : aao_file_model

`default_nettype wire

// ===== sim/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] IDX_BASE = 12'h100;

  logic        core_clk, rst, instr_valid, instr_ready, ext_set_en;
  logic [15:0] instr_word;
  logic [3:0]  bank_select_register;
  logic [11:0] file_addr;
  logic        file_indexed, file_rd_en, file_wr_en, instr_done, instr_unsupported;
  logic [7:0]  file_rd_data, file_wr_data, accumulator;
  logic        negative_flag, signed_wrap_flag, zero_flag, half_carry_flag, carry_flag;
  logic [7:0]  eacc;
  logic [4:0]  ef;
  int          n_mismatch, checks_done;

  aao_alu u_dut (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .ext_set_en(ext_set_en),
    .bank_select_register(bank_select_register), .file_addr(file_addr),
    .file_indexed(file_indexed), .file_rd_en(file_rd_en), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .accumulator(accumulator),
    .negative_flag(negative_flag), .signed_wrap_flag(signed_wrap_flag),
    .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .carry_flag(carry_flag),
    .instr_done(instr_done), .instr_unsupported(instr_unsupported));

  aao_file_model #(.IDX_BASE(IDX_BASE)) u_mem (
    .core_clk(core_clk), .rst(rst), .file_addr(file_addr), .file_indexed(file_indexed),
    .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Issues one word, follows the file port and compares against the tracked state.
  task automatic exec(input logic [15:0] w, input logic ext, input logic [3:0] bank);
    logic        add_l, and_l, isf, adc_f, d, idx, cin, ga_i;
    logic [7:0]  k, b, fv, r, gwd;
    logic [8:0]  s;
    logic [11:0] ea, ma, ga;
    int          cyc, nrd, nwr;
    k = w[7:0];
    d = w[9];
    add_l = w[15:8] == 8'h0f;
    and_l = w[15:8] == 8'h0b;
    adc_f = w[15:10] == 6'h08;
    isf = adc_f | (w[15:10] == 6'h09);
    idx = isf & ext & ~w[8] & (k <= 8'h5f);
    ea = w[8] ? {bank, k} : {(k <= 8'h5f) ? 4'h0 : 4'hf, k};
    ma = idx ? IDX_BASE + {4'h0, k} : ea;
    fv = u_mem.mem[ma];
    @(posedge core_clk);
    ext_set_en <= ext;
    bank_select_register <= bank;
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    cyc = 0;
    nrd = 0;
    nwr = 0;
    while (instr_done !== 1'b1 && cyc < 20) begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (file_rd_en === 1'b1) begin
        nrd++;
        ga = file_addr;
        ga_i = file_indexed;
      end
      if (file_wr_en === 1'b1) begin
        nwr++;
        gwd = file_wr_data;
      end
    end
    b = add_l ? k : fv;
    cin = adc_f & ef[0];
    s = {1'b0, eacc} + {1'b0, b} + {8'h00, cin};
    r = s[7:0];
    if (add_l | isf) begin
      ef = {r[7], (eacc[7] == b[7]) && (r[7] != eacc[7]), r == 8'h00,
            ({1'b0, eacc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0f, s[8]};
    end else if (and_l) begin
      r = eacc & k;
      ef[4] = r[7];
      ef[2] = r == 8'h00;
    end
    if (add_l | and_l | (isf & ~d)) eacc = r;
    // The take edge lies before the loop, so done follows four counted edges.
    chk(16'(cyc), 16'h0004, "done latency");
    chk({8'h00, accumulator}, {8'h00, eacc}, "accumulator");
    chk({11'h0, negative_flag, signed_wrap_flag, zero_flag, half_carry_flag, carry_flag},
        {11'h0, ef}, "flags");
    chk({15'h0, instr_unsupported}, {15'h0, ~(add_l | and_l | isf)}, "opcode");
    chk({15'h0, instr_ready}, 16'h0001, "ready");
    chk(16'(nrd), {15'h0, isf}, "reads");
    chk(16'(nwr), {15'h0, isf & d}, "writes");
    if (isf) begin
      chk({4'h0, ga}, {4'h0, idx ? {4'h0, k} : ea}, "address");
      chk({15'h0, ga_i}, {15'h0, idx}, "indexed");
      chk({8'h00, u_mem.mem[ma]}, {8'h00, d ? r : fv}, "file byte");
    end
    if (isf & d) chk({8'h00, gwd}, {8'h00, r}, "write data");
  endtask : exec

  task automatic t_reset;
    chk({5'h0, accumulator, carry_flag, zero_flag, instr_ready}, 16'h0001, "reset state");
  endtask : t_reset

  task automatic t_add_literal;
    logic [7:0] lits [4] = '{8'h10, 8'h15, 8'h5b, 8'h80};
    foreach (lits[i]) exec({8'h0f, lits[i]}, 1'b0, 4'h0);
  endtask : t_add_literal

  task automatic t_and_literal;
    exec(16'h0fff, 1'b0, 4'h0);
    exec(16'h0fa4, 1'b0, 4'h0);
    exec(16'h0b5f, 1'b0, 4'h0);
    exec(16'h0b00, 1'b0, 4'h0);
  endtask : t_and_literal

  task automatic t_add_file;
    exec(16'h0f17, 1'b0, 4'h0);
    exec(16'h25c2, 1'b0, 4'h3);
    exec(16'h2680, 1'b0, 4'h3);
    exec(16'h265f, 1'b1, 4'h7);
    exec(16'h2460, 1'b1, 4'h7);
    exec(16'h2720, 1'b1, 4'ha);
  endtask : t_add_file

  task automatic t_add_carry_file;
    exec(16'h0fff, 1'b0, 4'h0);
    exec(16'h0f01, 1'b0, 4'h0);
    exec(16'h2110, 1'b0, 4'h5);
    exec(16'h2220, 1'b0, 4'h5);
    exec(16'h2030, 1'b1, 4'h5);
  endtask : t_add_carry_file

  task automatic t_unsupported;
    exec(16'h0900, 1'b0, 4'h0);
    exec(16'h2c11, 1'b0, 4'h0);
    exec(16'h0f01, 1'b0, 4'h0);
  endtask : t_unsupported

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    eacc = 8'h00;
    ef = 5'h00;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    bank_select_register = 4'h0;
    repeat (16) @(posedge core_clk);
    t_reset();
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_add_literal();
    t_and_literal();
    t_add_file();
    t_add_carry_file();
    t_unsupported();
    final_report();
  end

  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule : tb

`default_nettype wire
